//--- verilog/rss_regs.sv
// regulator sleep and sequencing register bank: regulator one sleep settings,
// regulator two mode, voltage, fault action and sequencer slots.
// assumes a simple register port from the control interface, sequencer strobes
// and fault pulses synchronous to ref_clk.
`timescale 1ns/1ps
module rss_regs #(
  parameter logic [15:0] ONE_LOW_POWER_DEFAULT = rss_pkg::RSS_RESET_ONE_LOW_POWER,
  parameter logic [15:0] TWO_CONTROL_DEFAULT = rss_pkg::RSS_RESET_TWO_CONTROL,
  parameter logic [15:0] TWO_TIMEOUTS_DEFAULT = rss_pkg::RSS_RESET_TWO_TIMEOUTS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sm_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic sleep_request_bit,
  input wire logic low_power_input_one,
  input wire logic low_power_input_two,
  input wire logic low_power_input_three,
  input wire logic reg_one_active_enable,
  input wire logic [4:0] reg_one_active_code,
  input wire logic reg_three_enable,
  input wire logic reg_four_enable,
  input wire rss_pkg::rss_seq_t seq,
  input wire logic reg_two_fault,
  output logic reg_one_sleeping,
  output logic reg_one_enable,
  output logic [4:0] reg_one_code,
  output logic [15:0] reg_one_mv,
  output logic reg_two_switch_mode,
  output logic reg_two_enable,
  output logic [15:0] reg_two_mv,
  output logic reg_two_discharge,
  output logic all_discharge,
  output logic fault_irq,
  output logic fault_reg_off,
  output logic fault_sys_off
);

  rss_pkg::rss_state_t st;
  rss_pkg::rss_state_t next_st;
  logic start_hit;
  logic stop_hit;
  logic one_src;
  logic all_off;
  logic [1:0] one_mode;
  logic [4:0] one_image;
  logic [4:0] two_select;
  logic [1:0] fault_act;

  // field views of the stored registers
  assign one_mode = st.one_low_power[rss_pkg::RSS_SLEEP_MODE_LSB +: 2];
  assign one_image = st.one_low_power[rss_pkg::RSS_VOLT_LSB +: 5];
  assign two_select = st.two_control[rss_pkg::RSS_VOLT_LSB +: 5];
  assign fault_act = st.two_timeouts[rss_pkg::RSS_FAULT_ACT_LSB +: 2];

  // sequencer slot decoders
  rss_slot_decode #(
    .SHUTDOWN(1'b0)
  ) u_start (
    .code(st.two_timeouts[rss_pkg::RSS_START_SLOT_LSB +: 4]),
    .seq(seq),
    .hit(start_hit)
  );

  rss_slot_decode #(
    .SHUTDOWN(1'b1)
  ) u_stop (
    .code(st.two_timeouts[rss_pkg::RSS_STOP_SLOT_LSB +: 4]),
    .seq(seq),
    .hit(stop_hit)
  );

  always_comb begin
    unique case (rss_pkg::rss_src_t'(st.one_low_power[rss_pkg::RSS_SLEEP_SRC_LSB +: 2]))
      rss_pkg::RSS_SRC_REG_BIT: one_src = sleep_request_bit;
      rss_pkg::RSS_SRC_LP_ONE: one_src = low_power_input_one;
      rss_pkg::RSS_SRC_LP_TWO: one_src = low_power_input_two;
      rss_pkg::RSS_SRC_LP_THREE: one_src = low_power_input_three;
    endcase
  end

  // all four regulators off at once
  assign all_off = !st.one_enable && !st.two_running && !reg_three_enable && !reg_four_enable;

  // next state: register writes, read data, regulator outputs
  always_comb begin
    next_st = st;
    // register writes, unimplemented bits dropped
    if (reg_write) begin
      unique case (reg_addr)
        rss_pkg::RSS_ADDR_ONE_LOW_POWER:
          next_st.one_low_power = reg_wdata & rss_pkg::RSS_MASK_ONE_LOW_POWER;
        rss_pkg::RSS_ADDR_TWO_CONTROL:
          next_st.two_control = reg_wdata & rss_pkg::RSS_MASK_TWO_CONTROL;
        rss_pkg::RSS_ADDR_TWO_TIMEOUTS:
          next_st.two_timeouts = reg_wdata & rss_pkg::RSS_MASK_TWO_TIMEOUTS;
        default: ;
      endcase
    end
    // read data, unmapped reads as zero
    if (reg_read) begin
      unique case (reg_addr)
        rss_pkg::RSS_ADDR_ONE_LOW_POWER: next_st.rdata = st.one_low_power;
        rss_pkg::RSS_ADDR_TWO_CONTROL: next_st.rdata = st.two_control;
        rss_pkg::RSS_ADDR_TWO_TIMEOUTS: next_st.rdata = st.two_timeouts;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    next_st.one_sleeping = one_src;
    next_st.one_enable = reg_one_active_enable;
    next_st.one_code = reg_one_active_code;
    if (one_src && one_mode == rss_pkg::RSS_SLEEP_OFF) begin
      next_st.one_enable = 1'b0;
    end else if (one_src && one_mode == rss_pkg::RSS_SLEEP_IMAGE) begin
      next_st.one_code = one_image;
    end
    next_st.one_mv = rss_pkg::rss_code_to_mv(next_st.one_code);
    if (st.two_control[rss_pkg::RSS_SWITCH_BIT]) begin
      next_st.two_mv = 16'h0000;
    end else begin
      next_st.two_mv = rss_pkg::rss_code_to_mv(two_select);
    end
    if (start_hit) begin
      next_st.two_running = 1'b1;
    end
    if (stop_hit) begin
      next_st.two_running = 1'b0;
    end
    // fault: interrupt always, then the coded action
    next_st.fault_irq = reg_two_fault;
    next_st.fault_reg_off = reg_two_fault && fault_act == rss_pkg::RSS_FAULT_REG_OFF;
    next_st.fault_sys_off = reg_two_fault && fault_act[1];
    if (next_st.fault_reg_off) begin
      next_st.two_running = 1'b0;
    end
    next_st.two_discharge = !st.two_running &&
      (!st.two_control[rss_pkg::RSS_FLOAT_BIT] || all_off);
    next_st.all_discharge = all_off;
    // state machine or power-on reset to defaults
    if (reset || sm_reset) begin
      next_st = '0;
      next_st.one_low_power = ONE_LOW_POWER_DEFAULT & rss_pkg::RSS_MASK_ONE_LOW_POWER;
      next_st.two_control = TWO_CONTROL_DEFAULT & rss_pkg::RSS_MASK_TWO_CONTROL;
      next_st.two_timeouts = TWO_TIMEOUTS_DEFAULT & rss_pkg::RSS_MASK_TWO_TIMEOUTS;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  // outputs straight from the state
  assign reg_rdata = st.rdata;
  assign reg_one_sleeping = st.one_sleeping;
  assign reg_one_enable = st.one_enable;
  assign reg_one_code = st.one_code;
  assign reg_one_mv = st.one_mv;
  assign reg_two_switch_mode = st.two_control[rss_pkg::RSS_SWITCH_BIT];
  assign reg_two_enable = st.two_running;
  assign reg_two_mv = st.two_mv;
  assign reg_two_discharge = st.two_discharge;
  assign all_discharge = st.all_discharge;
  assign fault_irq = st.fault_irq;
  assign fault_reg_off = st.fault_reg_off;
  assign fault_sys_off = st.fault_sys_off;

  property p_sleep_off;
    @(posedge ref_clk) disable iff (reset)
    (one_src && one_mode == 2'h1 && !sm_reset) |=> !reg_one_enable;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("regulator one not turned off in sleep");

  property p_source_two;
    @(posedge ref_clk) disable iff (reset)
    (st.one_low_power[9:8] == 2'b10 && !sm_reset) |=> reg_one_sleeping == $past(low_power_input_two);
  endproperty
  a_source_two: assert property (p_source_two)
    else $error("sleep source two not followed");

  property p_image_mv;
    @(posedge ref_clk) disable iff (reset)
    (one_src && one_mode == 2'h0 && !sm_reset) |=> reg_one_mv == rss_pkg::rss_code_to_mv($past(one_image));
  endproperty
  a_image_mv: assert property (p_image_mv)
    else $error("image voltage not applied");

  property p_switch;
    @(posedge ref_clk) disable iff (reset)
    (reg_two_switch_mode && !sm_reset) |=> reg_two_mv == 16'h0000;
  endproperty
  a_switch: assert property (p_switch)
    else $error("voltage select used in switch mode");

  property p_discharge;
    @(posedge ref_clk) disable iff (reset)
    (!reg_two_enable && !st.two_control[10] && !sm_reset) |=> reg_two_discharge;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("disabled regulator two not discharged");

  property p_all_off;
    @(posedge ref_clk) disable iff (reset)
    (all_off && !sm_reset) |=> all_discharge && reg_two_discharge;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("all-off discharge missing");

  property p_select_mv;
    @(posedge ref_clk) disable iff (reset)
    (!reg_two_switch_mode && !sm_reset) |=> reg_two_mv == rss_pkg::rss_code_to_mv($past(two_select));
  endproperty
  a_select_mv: assert property (p_select_mv)
    else $error("regulator two voltage wrong");

  property p_fault;
    @(posedge ref_clk) disable iff (reset)
    (reg_two_fault && !sm_reset) |=> fault_irq && (fault_sys_off == $past(fault_act[1])) &&
      (fault_reg_off == ($past(fault_act) == 2'h1));
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault action wrong");

  property p_start;
    @(posedge ref_clk) disable iff (reset)
    (start_hit && !stop_hit && !reg_two_fault && !sm_reset) |=> reg_two_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("regulator two not started");

  property p_stop;
    @(posedge ref_clk) disable iff (reset)
    (stop_hit && !sm_reset) |=> !reg_two_enable;
  endproperty
  a_stop: assert property (p_stop)
    else $error("regulator two not stopped");

  property p_defaults;
    @(posedge ref_clk) disable iff (reset)
    sm_reset |=> st.one_low_power == (ONE_LOW_POWER_DEFAULT & 16'h331f) && !reg_two_enable;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults not restored");

  property p_wake;
    @(posedge ref_clk) disable iff (reset)
    (!one_src && !sm_reset) |=> reg_one_enable == $past(reg_one_active_enable) &&
      reg_one_code == $past(reg_one_active_code);
  endproperty
  a_wake: assert property (p_wake)
    else $error("normal settings not restored");

endmodule

//--- verilog/rss_pkg.sv
// register map, field layout, reset values and decode helpers for the
// regulator sleep and sequencing register bank; no surrounding assumptions.
//
// Notes on behaviour
// - sleep behaviour 00 uses image voltage, 01 turns output off, 10/11 reserved.
// - sleep source 00 register bit, 01/10/11 low-power inputs one to three.
// - five-bit image voltage, default 1_1100, 50mV then 100mV steps.
// - mode bit set makes regulator two a switch; voltage select ignored.
// - regulator two disabled: discharge if float bit 0, float if 1.
// - all four regulators disabled: discharge every output regardless of float bits.
// - regulator two voltage from five-bit select, only while not a switch.
// - regulator two fault always interrupts; 00 ignore, 01 regulator off, 1x system off.
// - start code 0000 never, 0001-1110 in that slot, 1111 on entering active.
// - stop code 0001-1110 in that slot, 0000 and 1111 on entering off.
// - power state machine reset restores mask-option defaults, not only power-on.
package rss_pkg;

  // register offsets
  localparam logic [7:0] RSS_ADDR_ONE_LOW_POWER = 8'hca;
  localparam logic [7:0] RSS_ADDR_TWO_CONTROL = 8'hcb;
  localparam logic [7:0] RSS_ADDR_TWO_TIMEOUTS = 8'hcc;

  // implemented bits of each register
  localparam logic [15:0] RSS_MASK_ONE_LOW_POWER = 16'h331f;
  localparam logic [15:0] RSS_MASK_TWO_CONTROL = 16'h441f;
  localparam logic [15:0] RSS_MASK_TWO_TIMEOUTS = 16'hffc0;

  // reset values (mask option defaults)
  localparam logic [15:0] RSS_RESET_ONE_LOW_POWER = 16'h001c;
  localparam logic [15:0] RSS_RESET_TWO_CONTROL = 16'h001b;
  localparam logic [15:0] RSS_RESET_TWO_TIMEOUTS = 16'h0000;

  // field positions
  localparam int RSS_SLEEP_MODE_LSB = 12;
  localparam int RSS_SLEEP_SRC_LSB = 8;
  localparam int RSS_VOLT_LSB = 0;
  localparam int RSS_SWITCH_BIT = 14;
  localparam int RSS_FLOAT_BIT = 10;
  localparam int RSS_FAULT_ACT_LSB = 14;
  localparam int RSS_START_SLOT_LSB = 10;
  localparam int RSS_STOP_SLOT_LSB = 6;

  // codes
  localparam logic [1:0] RSS_SLEEP_IMAGE = 2'h0;
  localparam logic [1:0] RSS_SLEEP_OFF = 2'h1;
  localparam logic [1:0] RSS_FAULT_IGNORE = 2'h0;
  localparam logic [1:0] RSS_FAULT_REG_OFF = 2'h1;
  localparam logic [3:0] RSS_SLOT_NONE = 4'h0;
  localparam logic [3:0] RSS_SLOT_EDGE = 4'hf;

  // voltage steps in millivolts
  localparam logic [15:0] RSS_LOW_BASE_MV = 16'h0384;
  localparam logic [15:0] RSS_LOW_STEP_MV = 16'h0032;
  localparam logic [15:0] RSS_HIGH_BASE_MV = 16'h0708;
  localparam logic [15:0] RSS_HIGH_STEP_MV = 16'h0064;

  typedef enum logic [1:0] {
    RSS_SRC_REG_BIT = 2'b00,
    RSS_SRC_LP_ONE = 2'b01,
    RSS_SRC_LP_TWO = 2'b10,
    RSS_SRC_LP_THREE = 2'b11
  } rss_src_t;

  // whole state of the register bank
  typedef struct packed {
    logic [15:0] one_low_power;
    logic [15:0] two_control;
    logic [15:0] two_timeouts;
    logic [15:0] rdata;
    logic one_sleeping;
    logic one_enable;
    logic [4:0] one_code;
    logic [15:0] one_mv;
    logic [15:0] two_mv;
    logic two_running;
    logic two_discharge;
    logic all_discharge;
    logic fault_irq;
    logic fault_reg_off;
    logic fault_sys_off;
  } rss_state_t;

  // sequencer events as seen by the slot decoder
  typedef struct packed {
    logic start_strobe;
    logic stop_strobe;
    logic [3:0] slot;
    logic enter_active;
    logic enter_off;
  } rss_seq_t;

  // voltage code to millivolts, shared by image and select fields
  function automatic logic [15:0] rss_code_to_mv(input logic [4:0] code);
    logic [15:0] step;
    step = {12'h000, code[3:0]};
    if (code[4]) begin
      rss_code_to_mv = 16'(RSS_HIGH_BASE_MV + RSS_HIGH_STEP_MV * step);
    end else begin
      rss_code_to_mv = 16'(RSS_LOW_BASE_MV + RSS_LOW_STEP_MV * step);
    end
  endfunction

endpackage

//--- verilog/rss_slot_decode.sv
// slot decoder: says whether a four-bit slot code fires on this sequencer event
// assumes sequencer strobes are one-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps
module rss_slot_decode #(
  parameter bit SHUTDOWN = 1'b0
) (
  input wire logic [3:0] code,
  input wire rss_pkg::rss_seq_t seq,
  output logic hit
);

  // match slots 1 to 14 or the state-entry edge
  always_comb begin
    hit = 1'b0;
    if (SHUTDOWN) begin
      if (code == rss_pkg::RSS_SLOT_NONE || code == rss_pkg::RSS_SLOT_EDGE) begin
        hit = seq.enter_off;
      end else begin
        hit = seq.stop_strobe && (seq.slot == code);
      end
    end else begin
      if (code == rss_pkg::RSS_SLOT_EDGE) begin
        hit = seq.enter_active;
      end else if (code != rss_pkg::RSS_SLOT_NONE) begin
        hit = seq.start_strobe && (seq.slot == code);
      end
    end
  end

endmodule

//--- tb/rss_host_model.sv
// host side of the register port: single word writes and reads
// assumes ref_clk from the bench; strobes change just after a rising edge
`timescale 1ns/1ps
module rss_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [15:0] reg_wdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 16'h0000;
  end

  // one-cycle strobe, then a scrambled bus so stale values never pass
  task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= w;
    reg_read <= !w;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

//--- tb/rss_regs_tb_top.sv
// self-checking bench for the regulator sleep and sequencing register bank
// assumes the host model drives the register port; results compared on falling edges
`timescale 1ns/1ps
module rss_regs_tb_top;
  typedef struct packed {
    logic [2:0] sel;
    logic [15:0] val;
  } rss_note_t;
  logic ref_clk = 1'b0;
  logic reset, sm_reset, reg_one_active_enable, reg_three_enable, reg_four_enable;
  logic reg_two_fault, rd_pend, took, reg_write, reg_read, reg_one_sleeping, reg_one_enable;
  logic reg_two_switch_mode, reg_two_enable, reg_two_discharge, all_discharge;
  logic fault_irq, fault_reg_off, fault_sys_off;
  logic [3:0] lp;
  logic [4:0] reg_one_active_code, reg_one_code;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, reg_one_mv, reg_two_mv;
  rss_pkg::rss_seq_t seq;
  rss_note_t notes[$];
  int err_count = 0;
  int cmp_count = 0;
  int seed = 79622;
  string names[7] = '{"rdata", "one_mv", "two_mv", "one_state", "two_state", "fault", "all_off"};
  logic [7:0] adr[3] = '{8'hca, 8'hcb, 8'hcc};
  logic [15:0] dflt[3] = '{16'h001c, rss_pkg::RSS_RESET_TWO_CONTROL, 16'h0000};
  logic [15:0] msk[3] = '{16'h331f, 16'h441f, 16'hffc0};

  rss_regs dut (
    .ref_clk(ref_clk), .reset(reset), .sm_reset(sm_reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sleep_request_bit(lp[0]), .low_power_input_one(lp[1]), .low_power_input_two(lp[2]),
    .low_power_input_three(lp[3]), .reg_one_active_enable(reg_one_active_enable),
    .reg_one_active_code(reg_one_active_code), .reg_three_enable(reg_three_enable),
    .reg_four_enable(reg_four_enable), .seq(seq), .reg_two_fault(reg_two_fault),
    .reg_one_sleeping(reg_one_sleeping), .reg_one_enable(reg_one_enable),
    .reg_one_code(reg_one_code), .reg_one_mv(reg_one_mv),
    .reg_two_switch_mode(reg_two_switch_mode), .reg_two_enable(reg_two_enable),
    .reg_two_mv(reg_two_mv), .reg_two_discharge(reg_two_discharge),
    .all_discharge(all_discharge), .fault_irq(fault_irq), .fault_reg_off(fault_reg_off),
    .fault_sys_off(fault_sys_off)
  );
  rss_host_model host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata)
  );

  // 50 MHz clock
  initial forever #10 ref_clk = ~ref_clk;

  function automatic logic [15:0] mv(input logic [4:0] c);
    mv = c[4] ? 16'h0708 + 16'h0064 * c[3:0] : 16'h0384 + 16'h0032 * c[3:0];
  endfunction

  function automatic logic [15:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = reg_rdata;
      3'h1: obs = reg_one_mv;
      3'h2: obs = reg_two_mv;
      3'h3: obs = {9'h000, reg_one_sleeping, reg_one_enable, reg_one_code};
      3'h4: obs = {12'h000, reg_two_switch_mode, reg_two_enable, reg_two_discharge, all_discharge};
      3'h5: obs = {13'h0, fault_irq, fault_reg_off, fault_sys_off};
      default: obs = {15'h0, all_discharge};
    endcase
  endfunction

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic note(input logic [2:0] s, input logic [15:0] v);
    notes.push_back('{s, v});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    note(3'h0, exp);
    host.access(a, 16'h0000, 1'b0);
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse_seq(input logic [7:0] v);
    @(posedge ref_clk);
    seq <= v;
    @(posedge ref_clk);
    seq <= 8'h00;
    settle();
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // read data lands one edge after the read strobe; other notes are already settled
  always @(posedge ref_clk) rd_pend <= reg_read;
  // all settled notes go at once, so none waits into the next stimulus
  always @(negedge ref_clk) begin
    took = 1'b0;
    while (notes.size() > 0 && (notes[0].sel != 3'h0 || (rd_pend && !took))) begin
      took = took || (notes[0].sel == 3'h0);
      check(names[notes[0].sel], obs(notes[0].sel), notes[0].val);
      void'(notes.pop_front());
    end
  end

  // watchdog against a hung run
  initial begin
    #100000;
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    logic [4:0] c;
    logic [3:0] k;
    {reset, sm_reset, reg_two_fault, lp} = 7'h40;
    {reg_one_active_enable, reg_three_enable, reg_four_enable} = 3'h7;
    reg_one_active_code = 5'h10;
    seq = 8'h00;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    // defaults, masks, unmapped place, then state machine reset
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 3; i++) begin
        rd(adr[i], dflt[i]);
        host.access(adr[i], 16'hffff, 1'b1);
        rd(adr[i], msk[i]);
      end
      host.access(8'hcd, 16'hffff, 1'b1);
      rd(8'hcd, 16'h0000);
      sm_reset <= 1'b1;
      @(posedge ref_clk);
      sm_reset <= 1'b0;
    end
    // voltage codes of select and image fields
    for (int i = 0; i < 6; i++) begin
      c = 5'($random(seed));
      host.access(8'hcb, {11'h000, c}, 1'b1);
      host.access(8'hca, {11'h000, ~c}, 1'b1);
      reg_one_active_code <= c;
      lp <= {3'h0, i[0]};
      settle();
      note(3'h2, mv(c));
      note(3'h1, mv(i[0] ? ~c : c));
      note(3'h3, {9'h000, i[0], 1'b1, i[0] ? ~c : c});
    end
    host.access(8'hcb, 16'h4005, 1'b1);
    reg_one_active_code <= 5'h10;
    settle();
    note(3'h2, 16'h0000);
    note(3'h4, 16'h000a);
    // every sleep source with output-off behaviour, others driven to the opposite level
    for (int s = 0; s < 4; s++) begin
      host.access(8'hca, 16'h101c | (16'(s) << 8), 1'b1);
      lp <= ~(4'h1 << s);
      settle();
      note(3'h3, 16'h0030);
      lp <= 4'h1 << s;
      settle();
      note(3'h3, 16'h0050);
    end
    host.access(8'hca, 16'h201c, 1'b1);
    lp <= 4'h1;
    settle();
    note(3'h3, 16'h0070);
    lp <= 4'h0;
    host.access(8'hcb, 16'h001b, 1'b1);
    // start and stop in random slots, wrong slot first
    for (int i = 0; i < 4; i++) begin
      k = 4'h1 + 4'($unsigned($random(seed)) % 32'h0000000e);
      host.access(8'hcc, {2'h0, k, 4'hf - k, 6'h00}, 1'b1);
      pulse_seq({2'b10, k ^ 4'h1, 2'b00});
      note(3'h4, 16'h0002);
      pulse_seq({2'b10, k, 2'b00});
      note(3'h4, 16'h0004);
      pulse_seq({2'b01, 4'hf - k, 2'b00});
      note(3'h4, 16'h0002);
    end
    // edge codes: start on active entry, stop codes 0 and 15 on off entry
    for (int i = 0; i < 2; i++) begin
      host.access(8'hcc, {2'h0, 4'hf, i[0] ? 4'hf : 4'h0, 6'h00}, 1'b1);
      pulse_seq(8'h02);
      note(3'h4, 16'h0004);
      pulse_seq(8'h01);
      note(3'h4, 16'h0002);
    end
    host.access(8'hcc, 16'h0000, 1'b1);
    pulse_seq(8'h80);
    pulse_seq(8'h02);
    note(3'h4, 16'h0002);
    // float bit set, then every regulator off
    host.access(8'hcb, 16'h041b, 1'b1);
    settle();
    note(3'h4, 16'h0000);
    {reg_one_active_enable, reg_three_enable, reg_four_enable} <= 3'h0;
    settle();
    note(3'h6, 16'h0001);
    note(3'h4, 16'h0003);
    reg_four_enable <= 1'b1;
    settle();
    note(3'h6, 16'h0000);
    {reg_one_active_enable, reg_three_enable, reg_four_enable} <= 3'h7;
    // each fault action while running
    for (int a = 0; a < 4; a++) begin
      host.access(8'hcc, {2'(a), 4'h1, 4'h2, 6'h00}, 1'b1);
      pulse_seq(8'h84);
      @(posedge ref_clk);
      reg_two_fault <= 1'b1;
      @(posedge ref_clk);
      reg_two_fault <= 1'b0;
      note(3'h5, {13'h0, 1'b1, a == 1, a > 1});
      settle();
      note(3'h4, {13'h0, a != 1, 2'b00});
      pulse_seq(8'h48);
    end
    settle();
    summarize();
  end
endmodule
